// ===== common/bya_pkg.sv
package bya_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0]  IDX_OPCODE      = 10'h000;
	localparam logic [9:0]  IDX_MODE        = 10'h001;
	localparam logic [9:0]  IDX_DST         = 10'h002;
	localparam logic [9:0]  IDX_SRC         = 10'h003;
	localparam logic [9:0]  IDX_CTRL        = 10'h004;
	localparam logic [9:0]  IDX_STAT        = 10'h005;
	localparam logic [9:0]  IDX_FLAGS       = 10'h0D5;
	localparam int          ADDR_W          = 12;

	// Status flags field positions
	localparam int          FLG_C           = 7;
	localparam int          FLG_Z           = 6;
	localparam int          FLG_S           = 5;
	localparam int          FLG_V           = 4;
	localparam int          FLG_D           = 3;
	localparam int          FLG_H           = 2;
	localparam logic [7:0]  FLAGS_RST       = 8'h00;
	localparam logic [7:0]  OPND_RST        = 8'h00;

	// Control and status fields
	localparam int          CTRL_START      = 0;
	localparam int          STAT_BUSY       = 0;
	localparam int          STAT_DONE       = 1;
	localparam int          STAT_BAD        = 2;
	localparam int          STAT_BYTES_LSB  = 4;
	localparam int          STAT_CYC_LSB    = 8;

	// Opcode encodings
	localparam logic [3:0]  BASE_ADD        = 4'h0;
	localparam logic [3:0]  BASE_ADC        = 4'h1;
	localparam logic [3:0]  BASE_AND        = 4'h5;
	localparam logic [3:0]  LO_WORK         = 4'h2;
	localparam logic [3:0]  LO_WORK_IND     = 4'h3;
	localparam logic [3:0]  LO_REG_IMM      = 4'h6;
	localparam logic [7:0]  OPC_BIT_AND     = 8'h67;
	localparam logic [7:0]  OPC_BIT_CMP     = 8'h17;

	// Instruction lengths and cycle counts
	localparam logic [1:0]  BYTES_SHORT     = 2'h2;
	localparam logic [1:0]  BYTES_LONG      = 2'h3;
	localparam logic [2:0]  CYC_SHORT       = 3'h4;
	localparam logic [2:0]  CYC_LONG        = 3'h6;

	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_ADC  = 3'b001,
		OP_ADD  = 3'b010,
		OP_AND  = 3'b011,
		OP_BAND = 3'b100,
		OP_BCP  = 3'b101
	} bya_op_e;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_EXEC = 1'b1
	} bya_state_e;

	typedef enum logic [2:0] {
		SEL_NONE  = 3'b000,
		SEL_OPC   = 3'b001,
		SEL_MODE  = 3'b010,
		SEL_DST   = 3'b011,
		SEL_SRC   = 3'b100,
		SEL_CTRL  = 3'b101,
		SEL_STAT  = 3'b110,
		SEL_FLAGS = 3'b111
	} bya_sel_e;
endpackage

// ===== common/bya_alu_if.sv
`timescale 1ns/100ps
interface bya_alu_if;
	logic [7:0]        opcode;
	logic [7:0]        mode;
	logic [7:0]        dst;
	logic [7:0]        src;
	logic [7:0]        flags_in;
	bya_pkg::bya_op_e  op;
	logic [7:0]        result;
	logic [7:0]        flags_out;
	logic [1:0]        bytes;
	logic [2:0]        cycles;

	modport ctrl (output opcode, mode, dst, src, flags_in, input op, result, flags_out, bytes, cycles);
	modport core (input opcode, mode, dst, src, flags_in, output op, result, flags_out, bytes, cycles);
endinterface

// ===== hw/bya_alu_core.sv
`timescale 1ns/100ps
module bya_alu_core (
	bya_alu_if.core alu
);
	function automatic bya_pkg::bya_op_e decode_op(input logic [7:0] opc, input logic dir);
		logic lo_ok;
		lo_ok = opc[3:0] >= bya_pkg::LO_WORK && opc[3:0] <= bya_pkg::LO_REG_IMM;
		if (opc == bya_pkg::OPC_BIT_AND)
			return bya_pkg::OP_BAND;
		// Compare exists only in the destination-bit-0 form
		if (opc == bya_pkg::OPC_BIT_CMP && !dir)
			return bya_pkg::OP_BCP;
		if (lo_ok && opc[7:4] == bya_pkg::BASE_ADC)
			return bya_pkg::OP_ADC;
		if (lo_ok && opc[7:4] == bya_pkg::BASE_ADD)
			return bya_pkg::OP_ADD;
		if (lo_ok && opc[7:4] == bya_pkg::BASE_AND)
			return bya_pkg::OP_AND;
		return bya_pkg::OP_NONE;
	endfunction

	wire        dir       = alu.mode[0];
	wire [2:0]  bidx      = alu.mode[3:1];
	wire        cin       = (alu.op == bya_pkg::OP_ADC) & alu.flags_in[bya_pkg::FLG_C];
	wire [8:0]  sum9      = {1'b0, alu.dst} + {1'b0, alu.src} + {8'h00, cin};
	wire [4:0]  sum5      = {1'b0, alu.dst[3:0]} + {1'b0, alu.src[3:0]} + {4'h0, cin};
	wire        add_v     = (alu.dst[7] == alu.src[7]) && (sum9[7] != alu.dst[7]);
	wire [7:0]  and_res   = alu.dst & alu.src;
	wire        src_bit   = dir ? alu.src[0] : alu.src[bidx];
	wire        dst_bit   = dir ? alu.dst[bidx] : alu.dst[0];
	wire        bit_res   = src_bit & dst_bit;
	wire [2:0]  bpos      = dir ? bidx : 3'h0;
	wire        cmp_eq    = alu.dst[0] == alu.src[bidx];
	logic [7:0] band_res;

	assign alu.op = decode_op(alu.opcode, dir);

	always_comb begin
		band_res       = alu.dst;
		band_res[bpos] = bit_res;
	end

	always_comb begin
		alu.result    = alu.dst;
		alu.flags_out = alu.flags_in;
		unique case (alu.op)
			bya_pkg::OP_ADC, bya_pkg::OP_ADD: begin
				alu.result                    = sum9[7:0];
				alu.flags_out[bya_pkg::FLG_C] = sum9[8];
				alu.flags_out[bya_pkg::FLG_Z] = sum9[7:0] == 8'h00;
				alu.flags_out[bya_pkg::FLG_S] = sum9[7];
				alu.flags_out[bya_pkg::FLG_V] = add_v;
				alu.flags_out[bya_pkg::FLG_D] = 1'b0;
				alu.flags_out[bya_pkg::FLG_H] = sum5[4];
			end
			bya_pkg::OP_AND: begin
				alu.result                    = and_res;
				alu.flags_out[bya_pkg::FLG_Z] = and_res == 8'h00;
				alu.flags_out[bya_pkg::FLG_S] = and_res[7];
				alu.flags_out[bya_pkg::FLG_V] = 1'b0;
			end
			bya_pkg::OP_BAND: begin
				// Overflow flag kept as is so runs stay reproducible
				alu.result                    = band_res;
				alu.flags_out[bya_pkg::FLG_Z] = !bit_res;
				alu.flags_out[bya_pkg::FLG_S] = 1'b0;
			end
			bya_pkg::OP_BCP: begin
				alu.result                    = alu.dst;
				alu.flags_out[bya_pkg::FLG_Z] = cmp_eq;
				alu.flags_out[bya_pkg::FLG_S] = 1'b0;
			end
			bya_pkg::OP_NONE: begin
				alu.result    = alu.dst;
				alu.flags_out = alu.flags_in;
			end
		endcase
	end

	wire short_fmt = alu.op inside {bya_pkg::OP_ADC, bya_pkg::OP_ADD, bya_pkg::OP_AND}
		&& alu.opcode[3:0] <= bya_pkg::LO_WORK_IND;

	assign alu.bytes  = short_fmt ? bya_pkg::BYTES_SHORT : bya_pkg::BYTES_LONG;
	assign alu.cycles = (short_fmt && alu.opcode[3:0] == bya_pkg::LO_WORK) ? bya_pkg::CYC_SHORT
		: bya_pkg::CYC_LONG;
endmodule

// ===== hw/bya_alu.sv
// Notes on behaviour
// - Add-with-carry writes dst+src+carry into destination; source stays.
// - Plain add writes dst+src into destination; source stays.
// - Both adds set carry on carry out of bit 7, else clear.
// - Both adds set zero on zero result, sign on negative result.
// - Both adds set overflow when same-sign operands give opposite-sign result.
// - Both adds set half carry from bit 3 and clear the decimal flag.
// - Bases 1x, 0x, 5x; low nibble 2..6 picks mode, length, cycles.
// - Bitwise AND writes dst AND src into destination; source stays.
// - AND sets zero, sign from bit 7, clears overflow, keeps others.
// - Bit AND combines src bit b with dst bit 0, or reverse.
// - Bit AND changes only the chosen destination bit.
// - Bit AND sets zero on zero result, clears sign, keeps the rest.
// - Second byte: register address, bit index, direction flag.
// - Bit AND and bit compare take three bytes and six cycles.
// - Bit compare sets zero when dst bit 0 equals src bit b.
// - Bit compare writes nothing back.
// - Status flags live at register index D5.
`timescale 1ns/100ps
module bya_alu (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	// AXI4-Lite write address and data
	input  wire logic [11:0] s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output wire logic        s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output wire logic        s_axi_wready_o,
	// AXI4-Lite write response
	output wire logic [1:0]  s_axi_bresp_o,
	output wire logic        s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	// AXI4-Lite read
	input  wire logic [11:0] s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output wire logic        s_axi_arready_o,
	output wire logic [31:0] s_axi_rdata_o,
	output wire logic [1:0]  s_axi_rresp_o,
	output wire logic        s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// Flags towards the condition-code logic
	output wire logic [7:0]  status_flags_o
);
	function automatic bya_pkg::bya_sel_e map_addr(input logic [11:0] a);
		if (a[1:0] != 2'h0)
			return bya_pkg::SEL_NONE;
		unique case (a[11:2])
			bya_pkg::IDX_OPCODE: return bya_pkg::SEL_OPC;
			bya_pkg::IDX_MODE:   return bya_pkg::SEL_MODE;
			bya_pkg::IDX_DST:    return bya_pkg::SEL_DST;
			bya_pkg::IDX_SRC:    return bya_pkg::SEL_SRC;
			bya_pkg::IDX_CTRL:   return bya_pkg::SEL_CTRL;
			bya_pkg::IDX_STAT:   return bya_pkg::SEL_STAT;
			bya_pkg::IDX_FLAGS:  return bya_pkg::SEL_FLAGS;
			default:             return bya_pkg::SEL_NONE;
		endcase
	endfunction

	bya_alu_if alu ();

	bya_alu_core u_core (
		.alu (alu)
	);

	localparam logic [7:0] OPND_RST_8 = bya_pkg::OPND_RST;

	// Bus write side
	logic        aw_hold_reg;
	logic [11:0] awaddr_reg;
	logic        w_hold_reg;
	logic [31:0] wdata_reg;
	logic        wlane_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	// Bus read side
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	// Datapath state
	logic [7:0]  opcode_reg;
	logic [7:0]  mode_reg;
	logic [7:0]  dst_reg;
	logic [7:0]  src_reg;
	logic [7:0]  flags_reg;
	logic        done_reg;
	logic        bad_reg;
	logic [2:0]  cnt_reg;
	logic [2:0]  cnt_next;
	bya_pkg::bya_state_e state_reg;
	bya_pkg::bya_state_e state_next;

	wire                aw_take   = s_axi_awvalid_i && !aw_hold_reg;
	wire                w_take    = s_axi_wvalid_i && !w_hold_reg;
	wire                do_write  = aw_hold_reg && w_hold_reg && !bvalid_reg;
	wire bya_pkg::bya_sel_e wr_sel = map_addr(awaddr_reg);
	wire bya_pkg::bya_sel_e rd_sel = map_addr(s_axi_araddr_i);
	wire                ar_take   = s_axi_arvalid_i && !rvalid_reg;
	wire                busy      = state_reg == bya_pkg::ST_EXEC;
	wire                wr_lo     = do_write && wlane_reg;
	// Operands are frozen while an operation runs, so a late write cannot tear it
	wire                sw_free   = wr_lo && !busy;
	wire                start     = sw_free && wr_sel == bya_pkg::SEL_CTRL && wdata_reg[bya_pkg::CTRL_START];
	wire                legal     = alu.op != bya_pkg::OP_NONE;
	wire                go        = start && legal;
	wire                commit    = busy && cnt_reg == 3'h0;
	wire                done_clr  = wr_lo && wr_sel == bya_pkg::SEL_STAT && wdata_reg[bya_pkg::STAT_DONE];
	wire                bad_clr   = wr_lo && wr_sel == bya_pkg::SEL_STAT && wdata_reg[bya_pkg::STAT_BAD];

	wire [7:0] opcode_next = (sw_free && wr_sel == bya_pkg::SEL_OPC) ? wdata_reg[7:0] : opcode_reg;
	wire [7:0] mode_next   = (sw_free && wr_sel == bya_pkg::SEL_MODE) ? wdata_reg[7:0] : mode_reg;
	wire [7:0] src_next    = (sw_free && wr_sel == bya_pkg::SEL_SRC) ? wdata_reg[7:0] : src_reg;
	wire [7:0] dst_next    = commit ? alu.result
		: (sw_free && wr_sel == bya_pkg::SEL_DST) ? wdata_reg[7:0] : dst_reg;
	wire [7:0] flags_next  = commit ? alu.flags_out
		: (sw_free && wr_sel == bya_pkg::SEL_FLAGS) ? wdata_reg[7:0] : flags_reg;
	// Hardware set beats a software clear in the same cycle
	wire       done_next   = commit || (done_reg && !done_clr);
	wire       bad_next    = (start && !legal) || (bad_reg && !bad_clr);

	wire [31:0] stat_word = {20'h0_0000, 1'b0, alu.cycles, 2'h0, alu.bytes, 1'b0, bad_reg, done_reg, busy};
	logic [31:0] rd_word;

	assign alu.opcode   = opcode_reg;
	assign alu.mode     = mode_reg;
	assign alu.dst      = dst_reg;
	assign alu.src      = src_reg;
	assign alu.flags_in = flags_reg;

	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (rd_sel)
			bya_pkg::SEL_OPC:   rd_word[7:0] = opcode_reg;
			bya_pkg::SEL_MODE:  rd_word[7:0] = mode_reg;
			bya_pkg::SEL_DST:   rd_word[7:0] = dst_reg;
			bya_pkg::SEL_SRC:   rd_word[7:0] = src_reg;
			bya_pkg::SEL_CTRL:  rd_word = 32'h0000_0000;
			bya_pkg::SEL_STAT:  rd_word = stat_word;
			bya_pkg::SEL_FLAGS: rd_word[7:0] = flags_reg;
			bya_pkg::SEL_NONE:  rd_word = 32'h0000_0000;
		endcase
	end

	// Operation sequencer
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		unique case (state_reg)
			bya_pkg::ST_IDLE: begin
				if (go) begin
					state_next = bya_pkg::ST_EXEC;
					cnt_next   = alu.cycles - 3'h1;
				end
			end
			bya_pkg::ST_EXEC: begin
				if (commit)
					state_next = bya_pkg::ST_IDLE;
				else
					cnt_next = cnt_reg - 3'h1;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			rvalid_reg  <= 1'b0;
		end else begin
			aw_hold_reg <= aw_take || (aw_hold_reg && !do_write);
			w_hold_reg  <= w_take || (w_hold_reg && !do_write);
			bvalid_reg  <= do_write || (bvalid_reg && !s_axi_bready_i);
			rvalid_reg  <= ar_take || (rvalid_reg && !s_axi_rready_i);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			awaddr_reg <= 12'h000;
			wdata_reg  <= 32'h0000_0000;
			wlane_reg  <= 1'b0;
			bresp_reg  <= bya_pkg::RESP_OKAY;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= bya_pkg::RESP_OKAY;
		end else begin
			if (aw_take)
				awaddr_reg <= s_axi_awaddr_i;
			if (w_take) begin
				wdata_reg <= s_axi_wdata_i;
				wlane_reg <= s_axi_wstrb_i[0];
			end
			if (do_write)
				bresp_reg <= (wr_sel == bya_pkg::SEL_NONE) ? bya_pkg::RESP_SLVERR : bya_pkg::RESP_OKAY;
			if (ar_take) begin
				rdata_reg <= rd_word;
				rresp_reg <= (rd_sel == bya_pkg::SEL_NONE) ? bya_pkg::RESP_SLVERR : bya_pkg::RESP_OKAY;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			opcode_reg <= OPND_RST_8;
			mode_reg   <= OPND_RST_8;
			dst_reg    <= OPND_RST_8;
			src_reg    <= OPND_RST_8;
			flags_reg  <= bya_pkg::FLAGS_RST;
			done_reg   <= 1'b0;
			bad_reg    <= 1'b0;
			state_reg  <= bya_pkg::ST_IDLE;
			cnt_reg    <= 3'h0;
		end else begin
			opcode_reg <= opcode_next;
			mode_reg   <= mode_next;
			dst_reg    <= dst_next;
			src_reg    <= src_next;
			flags_reg  <= flags_next;
			done_reg   <= done_next;
			bad_reg    <= bad_next;
			state_reg  <= state_next;
			cnt_reg    <= cnt_next;
		end
	end

	assign s_axi_awready_o = !aw_hold_reg;
	assign s_axi_wready_o  = !w_hold_reg;
	assign s_axi_bvalid_o  = bvalid_reg;
	assign s_axi_bresp_o   = bresp_reg;
	assign s_axi_arready_o = !rvalid_reg;
	assign s_axi_rvalid_o  = rvalid_reg;
	assign s_axi_rdata_o   = rdata_reg;
	assign s_axi_rresp_o   = rresp_reg;
	assign status_flags_o  = flags_reg;

	// Independent reference sums for the checks below
	wire       chk_cin   = (alu.op == bya_pkg::OP_ADC) && flags_reg[bya_pkg::FLG_C];
	wire [8:0] chk_sum9  = {1'b0, dst_reg} + {1'b0, src_reg} + {8'h00, chk_cin};
	wire [4:0] chk_sum5  = {1'b0, dst_reg[3:0]} + {1'b0, src_reg[3:0]} + {4'h0, chk_cin};
	wire       chk_add   = commit && (alu.op == bya_pkg::OP_ADC || alu.op == bya_pkg::OP_ADD);
	wire       chk_fa    = ar_take && rd_sel == bya_pkg::SEL_FLAGS;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	adc_sum_a: assert property (
		commit && alu.op == bya_pkg::OP_ADC |=> dst_reg == $past(chk_sum9[7:0]) && $stable(src_reg))
		else $error("add with carry result wrong");
	add_sum_a: assert property (
		commit && alu.op == bya_pkg::OP_ADD |=> dst_reg == $past(dst_reg + src_reg) && $stable(src_reg))
		else $error("plain add result wrong");
	add_carry_a: assert property (
		chk_add |=> flags_reg[bya_pkg::FLG_C] == $past(chk_sum9[8]))
		else $error("carry flag wrong after add");
	add_zs_a: assert property (
		chk_add |=> flags_reg[bya_pkg::FLG_Z] == (dst_reg == 8'h00) && flags_reg[bya_pkg::FLG_S] == dst_reg[7])
		else $error("zero or sign flag wrong after add");
	add_ovf_a: assert property (
		chk_add |=> flags_reg[bya_pkg::FLG_V] ==
			($past(dst_reg[7]) == $past(src_reg[7]) && dst_reg[7] != $past(dst_reg[7])))
		else $error("overflow flag wrong after add");
	add_dh_a: assert property (
		chk_add |=> !flags_reg[bya_pkg::FLG_D] && flags_reg[bya_pkg::FLG_H] == $past(chk_sum5[4]))
		else $error("decimal or half carry wrong after add");
	and_flags_a: assert property (
		commit && alu.op == bya_pkg::OP_AND |=> dst_reg == $past(dst_reg & src_reg)
			&& !flags_reg[bya_pkg::FLG_V] && flags_reg[bya_pkg::FLG_S] == dst_reg[7]
			&& flags_reg[bya_pkg::FLG_Z] == (dst_reg == 8'h00)
			&& $stable(flags_reg[bya_pkg::FLG_C]) && $stable(flags_reg[bya_pkg::FLG_D])
			&& $stable(flags_reg[bya_pkg::FLG_H]))
		else $error("logical and result or flags wrong");
	bit_only_a: assert property (
		commit && alu.op == bya_pkg::OP_BAND |=> $onehot0(dst_reg ^ $past(dst_reg))
			&& !flags_reg[bya_pkg::FLG_S] && $stable(flags_reg[bya_pkg::FLG_C]))
		else $error("bit and touched more than one bit");
	bcp_keep_a: assert property (
		commit && alu.op == bya_pkg::OP_BCP |=> $stable(dst_reg)
			&& flags_reg[bya_pkg::FLG_Z] == ($past(dst_reg[0]) == $past(src_reg[mode_reg[3:1]])))
		else $error("bit compare wrote or flagged wrongly");
	bit_len_a: assert property (
		go && alu.cycles == bya_pkg::CYC_LONG |=> busy [*6] ##1 !busy)
		else $error("six cycle operation has wrong length");
	short_len_a: assert property (
		go && alu.cycles == bya_pkg::CYC_SHORT |=> busy [*4] ##1 !busy)
		else $error("four cycle operation has wrong length");
	flags_read_a: assert property (
		chk_fa |=> rvalid_reg && rdata_reg == {24'h00_0000, $past(flags_reg)})
		else $error("status flags read back wrong");

	cov_adc_c: cover property (commit && alu.op == bya_pkg::OP_ADC && flags_reg[bya_pkg::FLG_C]);
	cov_band_c: cover property (commit && alu.op == bya_pkg::OP_BAND && mode_reg[0]);
	cov_bcp_c: cover property (commit && alu.op == bya_pkg::OP_BCP);
	cov_bad_c: cover property (start && !legal);
	cov_drop_c: cover property (wr_lo && busy && wr_sel == bya_pkg::SEL_DST);
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	typedef struct packed {
		logic [7:0] opc;
		logic [7:0] mode;
		logic [7:0] dst;
		logic [7:0] src;
		logic [7:0] flg;
	} bya_row_s;

	localparam logic [11:0] A_OPC  = {bya_pkg::IDX_OPCODE, 2'b00};
	localparam logic [11:0] A_MODE = {bya_pkg::IDX_MODE, 2'b00};
	localparam logic [11:0] A_DST  = {bya_pkg::IDX_DST, 2'b00};
	localparam logic [11:0] A_SRC  = {bya_pkg::IDX_SRC, 2'b00};
	localparam logic [11:0] A_CTRL = {bya_pkg::IDX_CTRL, 2'b00};
	localparam logic [11:0] A_STAT = {bya_pkg::IDX_STAT, 2'b00};
	localparam logic [11:0] A_FLG  = {bya_pkg::IDX_FLAGS, 2'b00};
	localparam logic [1:0]  OK     = bya_pkg::RESP_OKAY;

	logic        clk_sys_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [11:0] awaddr = 12'h000;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0]  wstrb = 4'hF;
	logic        wvalid = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready = 1'b0;
	logic [11:0] araddr = 12'h000;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready = 1'b0;
	logic [7:0]  status_flags;
	int          err_count = 0;
	int          checked = 0;

	// Carry-in on the first rows chains into the sum; low flag bits must survive every op
	bya_row_s rows [21] = '{
		'{8'h12, 8'h00, 8'h10, 8'h03, 8'h80}, '{8'h13, 8'h00, 8'hFF, 8'h00, 8'h80},
		'{8'h14, 8'h00, 8'h7F, 8'h00, 8'h80}, '{8'h15, 8'h00, 8'h10, 8'h03, 8'h00},
		'{8'h16, 8'h00, 8'h01, 8'h11, 8'h83}, '{8'h02, 8'h00, 8'h12, 8'h03, 8'hFF},
		'{8'h03, 8'h00, 8'h7F, 8'h01, 8'h00}, '{8'h04, 8'h00, 8'h80, 8'h80, 8'h00},
		'{8'h05, 8'h00, 8'h0F, 8'h01, 8'h00}, '{8'h06, 8'h00, 8'h01, 8'h25, 8'h00},
		'{8'h52, 8'h00, 8'h12, 8'h03, 8'h8C}, '{8'h53, 8'h00, 8'hF0, 8'h0F, 8'h10},
		'{8'h54, 8'h00, 8'h81, 8'h80, 8'h00}, '{8'h55, 8'h00, 8'h21, 8'h03, 8'h00},
		'{8'h56, 8'h00, 8'h21, 8'h25, 8'hFF}, '{8'h67, 8'h02, 8'h07, 8'h05, 8'h00},
		'{8'h67, 8'h03, 8'h05, 8'h07, 8'h9C}, '{8'h67, 8'h0F, 8'h80, 8'h01, 8'hFF},
		'{8'h67, 8'h0E, 8'h01, 8'h80, 8'h20}, '{8'h17, 8'h02, 8'h07, 8'h01, 8'h40},
		'{8'h17, 8'h0E, 8'h01, 8'h80, 8'hB4}};

	bya_alu bya_alu_inst (
		.clk_sys_i       (clk_sys_i),
		.rst_i           (rst_i),
		.s_axi_awaddr_i  (awaddr),
		.s_axi_awvalid_i (awvalid),
		.s_axi_awready_o (awready),
		.s_axi_wdata_i   (wdata),
		.s_axi_wstrb_i   (wstrb),
		.s_axi_wvalid_i  (wvalid),
		.s_axi_wready_o  (wready),
		.s_axi_bresp_o   (bresp),
		.s_axi_bvalid_o  (bvalid),
		.s_axi_bready_i  (bready),
		.s_axi_araddr_i  (araddr),
		.s_axi_arvalid_i (arvalid),
		.s_axi_arready_o (arready),
		.s_axi_rdata_o   (rdata),
		.s_axi_rresp_o   (rresp),
		.s_axi_rvalid_o  (rvalid),
		.s_axi_rready_i  (rready),
		.status_flags_o  (status_flags)
	);

	always #20 clk_sys_i = ~clk_sys_i;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: response %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge clk_sys_i);
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk_resp(bresp, er);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge clk_sys_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		rready <= 1'b0;
		chk_resp(rresp, er);
	endtask

	function automatic logic [15:0] model(input bya_row_s r);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] res;
		logic [7:0] f;
		logic       cin;
		logic [2:0] b;
		res = r.dst;
		f = r.flg;
		b = r.mode[3:1];
		cin = (r.opc[7:4] == bya_pkg::BASE_ADC) & r.flg[bya_pkg::FLG_C];
		f[bya_pkg::FLG_S] = 1'b0;
		if (r.opc == bya_pkg::OPC_BIT_AND) begin
			if (!r.mode[0]) res[0] = r.dst[0] & r.src[b];
			else res[b] = r.dst[b] & r.src[0];
			f[bya_pkg::FLG_Z] = ~res[r.mode[0] ? b : 3'd0];
		end else if (r.opc == bya_pkg::OPC_BIT_CMP) begin
			f[bya_pkg::FLG_Z] = (r.dst[0] == r.src[b]);
		end else if (r.opc[7:4] == bya_pkg::BASE_AND) begin
			res = r.dst & r.src;
			f[bya_pkg::FLG_Z] = (res == 8'h00);
			f[bya_pkg::FLG_S] = res[7];
			f[bya_pkg::FLG_V] = 1'b0;
		end else begin
			s = {1'b0, r.dst} + {1'b0, r.src} + {8'h00, cin};
			h = {1'b0, r.dst[3:0]} + {1'b0, r.src[3:0]} + {4'h0, cin};
			res = s[7:0];
			f[bya_pkg::FLG_C] = s[8];
			f[bya_pkg::FLG_Z] = (res == 8'h00);
			f[bya_pkg::FLG_S] = res[7];
			f[bya_pkg::FLG_V] = (r.dst[7] == r.src[7]) && (res[7] != r.dst[7]);
			f[bya_pkg::FLG_D] = 1'b0;
			f[bya_pkg::FLG_H] = h[4];
		end
		return {res, f};
	endfunction

	// Probe writes the destination while busy; the write must be dropped
	task automatic do_op(input bya_row_s r, input bit probe);
		logic [31:0] d;
		logic [15:0] e;
		logic [31:0] st;
		int          n;
		e = model(r);
		st = (r.opc[3:0] == bya_pkg::LO_WORK) ? 32'h0000_0422
			: (r.opc[3:0] == bya_pkg::LO_WORK_IND) ? 32'h0000_0622 : 32'h0000_0632;
		wr(A_FLG, r.flg, OK);
		wr(A_OPC, r.opc, OK);
		wr(A_MODE, r.mode, OK);
		wr(A_DST, r.dst, OK);
		wr(A_SRC, r.src, OK);
		wr(A_CTRL, 8'h01, OK);
		// Read and write overlap so both land while the operation still runs
		if (probe) begin
			fork
				rd(A_STAT, d, OK);
				wr(A_DST, 8'hAA, OK);
			join
			chk(d & 32'h0000_0001, 32'h0000_0001, "busy");
		end
		n = 0;
		do begin
			rd(A_STAT, d, OK);
			n++;
		end while (d[bya_pkg::STAT_DONE] !== 1'b1 && n < 50);
		chk(d & 32'h0000_0737, st, "length and cycles");
		rd(A_DST, d, OK);
		chk(d, {24'h00_0000, e[15:8]}, "result");
		rd(A_SRC, d, OK);
		chk(d, {24'h00_0000, r.src}, "source kept");
		rd(A_FLG, d, OK);
		chk(d, {24'h00_0000, e[7:0]}, "flags");
		chk({24'h00_0000, status_flags}, {24'h00_0000, e[7:0]}, "flag port");
		wr(A_STAT, 8'h06, OK);
		$display("Test op %h mode %h done", r.opc, r.mode);
	endtask

	task automatic wrap_up;
		$display("Comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		#(40 * 8000);
		err_count++;
		$display("Error at %0t: watchdog expired", $time);
		wrap_up();
	end

	initial begin
		logic [31:0] d;
		repeat (8) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		foreach (rows[i]) do_op(rows[i], 1'b0);
		do_op('{8'h14, 8'h00, 8'h7F, 8'h7F, 8'h00}, 1'b1);
		// Unsupported form of the bit compare is flagged and does nothing
		wr(A_DST, 8'h3C, OK);
		wr(A_OPC, bya_pkg::OPC_BIT_CMP, OK);
		wr(A_MODE, 8'h03, OK);
		wr(A_CTRL, 8'h01, OK);
		rd(A_STAT, d, OK);
		chk(d & 32'h0000_0007, 32'h0000_0004, "bad opcode");
		rd(A_DST, d, OK);
		chk(d, 32'h0000_003C, "dst after bad opcode");
		wr(A_STAT, 8'h04, OK);
		rd(A_STAT, d, OK);
		chk(d & 32'h0000_0007, 32'h0000_0000, "sticky cleared");
		$display("Test bad opcode done");
		rd(12'h018, d, bya_pkg::RESP_SLVERR);
		chk(d, 32'h0000_0000, "unmapped read");
		wr(A_FLG + 12'h002, 8'h11, bya_pkg::RESP_SLVERR);
		wr(A_FLG, 8'h5A, OK);
		rd(A_FLG, d, OK);
		chk(d, 32'h0000_005A, "flags readback");
		wstrb <= 4'h0;
		wr(A_FLG, 8'hA5, OK);
		wstrb <= 4'hF;
		rd(A_FLG, d, OK);
		chk(d, 32'h0000_005A, "lane off write dropped");
		$display("Test map done");
		@(posedge clk_sys_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rd(A_FLG, d, OK);
		chk(d, {24'h00_0000, bya_pkg::FLAGS_RST}, "flags reset");
		rd(A_DST, d, OK);
		chk(d, {24'h00_0000, bya_pkg::OPND_RST}, "dst reset");
		chk({24'h00_0000, status_flags}, 32'h0000_0000, "flag port reset");
		$display("Test reset done");
		wrap_up();
	end
endmodule
